// ==== design/pwm_ctl_pkg.sv ====
package pwm_ctl_pkg;
  // Data path widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 12;
  localparam int DUTY_W = 16;
  localparam int NUM_CH = 6;
  localparam int NUM_PAIR = 3;
  localparam int SYNC_W = 10;

  // Register byte addresses
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h20;
  localparam logic [7:0] CTRL_TWO_ADDR = 8'h21;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'h26;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'h27;
  localparam logic [7:0] PERIOD_HIGH_ADDR = 8'h28;
  localparam logic [7:0] PERIOD_LOW_ADDR = 8'h29;
  localparam logic [7:0] DUTY_BASE_ADDR = 8'h2A;
  localparam logic [7:0] MANUAL_ADDR = 8'h36;
  localparam logic [7:0] MAP_X_ADDR = 8'h37;
  localparam logic [7:0] MAP_Y_ADDR = 8'h38;

  // Control register one bit positions
  localparam int C1_ENABLE = 0;
  localparam int C1_LOAD_OK = 1;
  localparam int C1_CORR_LO = 2;
  localparam int C1_CORR_HI = 3;
  localparam int C1_FLAG = 4;
  localparam int C1_IRQ_EN = 5;
  localparam int C1_DIS_Y = 6;
  localparam int C1_DIS_X = 7;

  // Control register two bit positions
  localparam int C2_PSC_LO = 0;
  localparam int C2_CENTER = 2;
  localparam int C2_POL3 = 3;
  localparam int C2_POL1 = 5;
  localparam int C2_RATE_LO = 6;

  // Manual output register bit positions
  localparam int MN_OVERRIDE = 6;
  localparam int MN_COMPL = 7;

  // Correction select codes (upper bit set means current sensing)
  localparam logic [1:0] CORR_DEAD = 2'h2;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [11:0] COUNT_RST = 12'h000;
endpackage

// ==== design/pwm_timer_if.sv ====
`timescale 1ns/100ps
interface pwm_timer_if;
  logic run;                                  // Generator enabled
  logic tick;                                 // Prescaled count enable
  logic center;                               // Center-aligned mode
  logic [pwm_ctl_pkg::COUNT_W-1:0] modulus;   // Active modulus
  logic [pwm_ctl_pkg::COUNT_W-1:0] count;     // Live counter
  logic cyc_end;                              // Last tick of a PWM cycle
  logic half_pt;                              // Turning point of center mode

  // Counter side
  modport ctr (input run, tick, center, modulus, output count, cyc_end, half_pt);
  // Consumers of the count
  modport snk (input run, tick, center, modulus, count, cyc_end, half_pt);
endinterface

// ==== design/pwm_counter.sv ====
`timescale 1ns/100ps
module pwm_counter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Timer bundle
  pwm_timer_if.ctr t
);
  import pwm_ctl_pkg::*;

  logic up_r;                  // Counting direction, high while rising
  logic [COUNT_W:0] cnt_inc;   // Count plus one, one bit wider
  logic last_up;               // Next rising tick reaches the modulus

  assign cnt_inc = {1'b0, t.count} + {{COUNT_W{1'b0}}, 1'b1};
  assign last_up = cnt_inc >= {1'b0, t.modulus};

  // Cycle end and turning point strobes
  assign t.cyc_end = t.tick && (t.modulus != COUNT_RST) &&
                     (t.center ? (!up_r && t.count <= 12'h001) : last_up);
  assign t.half_pt = t.tick && t.center && up_r && last_up;

  // Counter: up/down in center mode, up-only in edge mode, down with a zero modulus
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      t.count <= COUNT_RST;
      up_r <= 1'b1;
    end else if (!t.run) begin
      // Held at zero while the generator is off
      t.count <= COUNT_RST;
      up_r <= 1'b1;
    end else if (t.tick) begin
      if (t.modulus == COUNT_RST) begin
        // Illegal modulus: endless count down through 0xFFF
        t.count <= t.count - 12'h001;
      end else if (!t.center) begin
        // Edge mode wraps after modulus ticks
        t.count <= last_up ? COUNT_RST : cnt_inc[COUNT_W-1:0];
      end else if (up_r) begin
        // Rising half of the triangle
        t.count <= last_up ? t.modulus : cnt_inc[COUNT_W-1:0];
        up_r <= !last_up;
      end else begin
        // Falling half, back to zero
        t.count <= (t.count <= 12'h001) ? COUNT_RST : t.count - 12'h001;
        up_r <= t.count <= 12'h001;
      end
    end
  end
endmodule

// ==== design/pwm_channel.sv ====
`timescale 1ns/100ps
module pwm_channel (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Timer bundle
  pwm_timer_if.snk t,
  // Duty value in effect
  input wire logic [pwm_ctl_pkg::DUTY_W-1:0] i_duty,
  // Raw channel output
  output logic o_on
);
  import pwm_ctl_pkg::*;

  logic off_all;   // Zero or negative duty
  logic on_all;    // Duty at or above the modulus

  assign off_all = i_duty[DUTY_W-1] || (i_duty == DUTY_RST);
  assign on_all = i_duty >= {4'h0, t.modulus};

  // Compare stage, forced low while the generator is off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_on <= 1'b0;
    end else if (!t.run) begin
      o_on <= 1'b0;
    end else if (off_all) begin
      o_on <= 1'b0;
    end else if (on_all) begin
      o_on <= 1'b1;
    end else begin
      o_on <= t.count < i_duty[COUNT_W-1:0];
    end
  end
endmodule

// ==== design/pwm_ctl_top.sv ====
// Function
// - Disabled pins float unless override selected
// - Disable clears counter and stops it
// - Disabled generator holds internal outputs low
// - Faults and manual pins work while disabled
// - Disable keeps reload flag and pending request
// - Clocks run in wait; interrupts wake
// - High byte read latches low byte
// - Modulus sets period, doubled when centered
// - Modulus buffered until load-ok reload; reads buffer
// - Modulus not reset; zero counts down forever
// - Six signed 16-bit duty values
// - Duty below one off, at modulus on
// - Complementary pairs share one duty value
// - Duty buffered until load-ok reload; reads buffer
// - Bank disables force pins; release next cycle or on override
// - Enabled reload flag raises interrupt
// - Reload flag sets every reload cycle
// - Flag cleared by read-set then write zero
// - Flag clear withdraws only reload interrupt
// - Correction select chooses polarity source
// - Dead-time sensing latches only when both off
// - Half or end sensing works at extremes
// - Load-ok set by read-zero write-one, self-clears
// - Reload every 1, 2, 4 or 8 cycles
`timescale 1ns/100ps
module pwm_ctl_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [pwm_ctl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pwm_ctl_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pwm_ctl_pkg::DATA_W-1:0] o_rdata,
  // Power stage pins
  output logic [pwm_ctl_pkg::NUM_CH-1:0] o_pwm,
  output logic [pwm_ctl_pkg::NUM_CH-1:0] o_pwm_oe_n,
  input wire logic [pwm_ctl_pkg::NUM_PAIR-1:0] i_sense_n,
  // Fault block levels
  input wire logic [pwm_ctl_pkg::NUM_CH-1:0] i_fault_off,
  input wire logic i_fault_irq,
  // Interrupt and wake
  output logic o_irq,
  output logic o_wake
);
  import pwm_ctl_pkg::*;

  pwm_timer_if tmr ();   // Counter bundle

  // Pin synchronisers
  logic [SYNC_W-1:0] sync1_r;   // First stage
  logic [SYNC_W-1:0] sync2_r;   // Second stage
  logic [NUM_PAIR-1:0] sense_s;   // Synced sense, high means use odd value
  logic [NUM_CH-1:0] fault_s;     // Synced fault disables
  logic fault_irq_s;              // Synced fault request

  // Control register one fields
  logic enable_r;
  logic load_ok_r;
  logic [1:0] corr_sel_r;
  logic flag_r;
  logic irq_en_r;
  logic dis_y_r;
  logic dis_x_r;
  // Control register two buffers, and the center bit used directly
  logic [1:0] psc_buf_r;
  logic center_r;
  logic [NUM_PAIR-1:0] pol_buf_r;
  logic [1:0] rate_buf_r;
  // Manual control
  logic [NUM_CH-1:0] man_out_r;
  logic override_r;
  logic compl_r;
  // Disable maps
  logic [NUM_CH-1:0] map_x_r;
  logic [NUM_CH-1:0] map_y_r;
  // Modulus buffer and active copy, both without reset
  logic [COUNT_W-1:0] mod_buf_r;
  logic [COUNT_W-1:0] mod_act_r;
  // Duty buffers and active copies
  logic [DUTY_W-1:0] duty_buf_r [NUM_CH];
  logic [DUTY_W-1:0] duty_act_r [NUM_CH];
  // Values taken at reload
  logic [1:0] psc_act_r;
  logic [1:0] rate_act_r;
  logic [NUM_PAIR-1:0] pol_act_r;
  // Sequencing
  logic enable_d_r;       // Enable one cycle late
  logic [2:0] psc_cnt_r;  // Prescaler divider
  logic [2:0] ld_cnt_r;   // Cycles since last reload
  logic flag_arm_r;       // Flag seen set by a read
  logic load_ok_arm_r;       // Load-ok seen clear by a read
  logic dis_x_act_r;      // Bank X disable in force
  logic dis_y_act_r;      // Bank Y disable in force
  logic [NUM_PAIR-1:0] sense_pick_r;   // Latched sense polarity
  logic [NUM_PAIR-1:0] pick_r;         // Register choice in this cycle
  logic [7:0] cnt_lo_latch_r;  // Low count byte held by high read
  logic cnt_latched_r;
  // Combinational terms
  logic first_rel;
  logic reload;
  logic do_load;
  logic cyc_start;
  logic [2:0] psc_mask;
  logic [2:0] rate_mask;
  logic wr_c1;
  logic rd_c1;
  logic [7:0] ctl1_val;
  logic [7:0] rdata_nxt;
  logic [NUM_CH-1:0] gen_on;
  logic [NUM_CH-1:0] pin_nxt;

  assign sense_s = ~sync2_r[NUM_PAIR-1:0];
  assign fault_s = sync2_r[NUM_PAIR+NUM_CH-1:NUM_PAIR];
  assign fault_irq_s = sync2_r[SYNC_W-1];

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_fault_irq, i_fault_off, i_sense_n};
      sync2_r <= sync1_r;
    end
  end

  // Timer bundle drive; the prescaler divides only while enabled.
  // No tick in the first reload cycle: the modulus is only loaded there
  assign psc_mask = 3'(({2'b00, 1'b1} << psc_act_r) - 3'h1);
  assign rate_mask = 3'(({2'b00, 1'b1} << rate_act_r) - 3'h1);
  assign tmr.run = enable_r;
  assign tmr.tick = enable_r && !first_rel && ((psc_cnt_r & psc_mask) == psc_mask);
  assign tmr.center = center_r;
  assign tmr.modulus = mod_act_r;

  // Reload timing: first enable, then every 1/2/4/8 cycles
  assign first_rel = enable_r && !enable_d_r;
  assign reload = first_rel || (tmr.cyc_end && ld_cnt_r == rate_mask);
  assign do_load = reload && load_ok_r;
  assign cyc_start = first_rel || tmr.cyc_end;
  assign wr_c1 = i_wr && i_addr == CTRL_ONE_ADDR;
  assign rd_c1 = i_rd && i_addr == CTRL_ONE_ADDR;

  pwm_counter u_counter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .t(tmr)
  );

  // Divider counters, cleared and stopped while disabled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      psc_cnt_r <= 3'h0;
      ld_cnt_r <= 3'h0;
      enable_d_r <= 1'b0;
    end else begin
      enable_d_r <= enable_r;
      psc_cnt_r <= enable_r ? psc_cnt_r + 3'h1 : 3'h0;
      if (!enable_r || reload) begin
        ld_cnt_r <= 3'h0;
      end else if (tmr.cyc_end) begin
        ld_cnt_r <= ld_cnt_r + 3'h1;
      end
    end
  end

  // Control register one, plain bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_r <= 1'b0;
      corr_sel_r <= 2'h0;
      irq_en_r <= 1'b0;
      dis_x_r <= 1'b0;
      dis_y_r <= 1'b0;
    end else if (wr_c1) begin
      // Disabling leaves the flag and request alone
      enable_r <= i_wdata[C1_ENABLE];
      corr_sel_r <= {i_wdata[C1_CORR_HI], i_wdata[C1_CORR_LO]};
      irq_en_r <= i_wdata[C1_IRQ_EN];
      dis_x_r <= i_wdata[C1_DIS_X];
      dis_y_r <= i_wdata[C1_DIS_Y];
    end
  end

  // Reload flag with read-then-write-zero clear; a reload wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_r <= 1'b0;
      flag_arm_r <= 1'b0;
    end else begin
      if (reload) begin
        flag_r <= 1'b1;
        flag_arm_r <= 1'b0;
      end else if (rd_c1 && flag_r) begin
        flag_arm_r <= 1'b1;
      end else if (wr_c1) begin
        // Sequence ends with any write
        flag_arm_r <= 1'b0;
        if (!i_wdata[C1_FLAG] && flag_arm_r) begin
          flag_r <= 1'b0;
        end
      end
    end
  end

  // Load-ok: read as zero, then write one; cleared by the load
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      load_ok_r <= 1'b0;
      load_ok_arm_r <= 1'b0;
    end else begin
      if (rd_c1) begin
        load_ok_arm_r <= !load_ok_r;
      end else if (wr_c1) begin
        load_ok_arm_r <= 1'b0;
      end
      if (wr_c1 && i_wdata[C1_LOAD_OK]) begin
        load_ok_r <= load_ok_r || load_ok_arm_r;
      end else if (wr_c1) begin
        load_ok_r <= 1'b0;
      end else if (do_load) begin
        load_ok_r <= 1'b0;
      end
    end
  end

  // Control register two, manual output and disable maps
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      psc_buf_r <= 2'h0;
      center_r <= 1'b0;
      pol_buf_r <= '0;
      rate_buf_r <= 2'h0;
      man_out_r <= '0;
      override_r <= 1'b0;
      compl_r <= 1'b0;
      map_x_r <= '0;
      map_y_r <= '0;
    end else if (i_wr) begin
      unique case (i_addr)
        CTRL_TWO_ADDR: begin
          psc_buf_r <= i_wdata[C2_PSC_LO+:2];
          center_r <= i_wdata[C2_CENTER];
          pol_buf_r <= i_wdata[C2_POL1:C2_POL3];
          rate_buf_r <= i_wdata[C2_RATE_LO+:2];
        end
        MANUAL_ADDR: begin
          man_out_r <= i_wdata[NUM_CH-1:0];
          override_r <= i_wdata[MN_OVERRIDE];
          compl_r <= i_wdata[MN_COMPL];
        end
        MAP_X_ADDR: map_x_r <= i_wdata[NUM_CH-1:0];
        MAP_Y_ADDR: map_y_r <= i_wdata[NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  // Modulus buffer and active copy carry no reset
  always_ff @(posedge i_clk) begin
    if (i_wr && i_addr == PERIOD_HIGH_ADDR) begin
      mod_buf_r[COUNT_W-1:8] <= i_wdata[3:0];
    end else if (i_wr && i_addr == PERIOD_LOW_ADDR) begin
      mod_buf_r[7:0] <= i_wdata;
    end
    if (do_load) begin
      mod_act_r <= mod_buf_r;
    end
  end

  // Values that follow every reload, and those gated by load-ok
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      psc_act_r <= 2'h0;
      rate_act_r <= 2'h0;
      pol_act_r <= '0;
    end else if (reload) begin
      rate_act_r <= rate_buf_r;
      pol_act_r <= pol_buf_r;
      if (load_ok_r) begin
        psc_act_r <= psc_buf_r;
      end
    end
  end

  // Per-channel duty buffer, active copy and comparator
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    localparam logic [7:0] HI_ADDR = 8'(DUTY_BASE_ADDR + 2 * k);
    localparam logic [7:0] LO_ADDR = 8'(DUTY_BASE_ADDR + 2 * k + 1);
    logic [DUTY_W-1:0] duty_use;   // Value fed to the comparator

    // Buffered writes, loaded only by a load-ok reload
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        duty_buf_r[k] <= DUTY_RST;
        duty_act_r[k] <= DUTY_RST;
      end else begin
        if (i_wr && i_addr == HI_ADDR) begin
          duty_buf_r[k][15:8] <= i_wdata;
        end else if (i_wr && i_addr == LO_ADDR) begin
          duty_buf_r[k][7:0] <= i_wdata;
        end
        if (do_load) begin
          duty_act_r[k] <= duty_buf_r[k];
        end
      end
    end

    // Complementary pairs use the picked register of the pair
    assign duty_use = compl_r ? duty_act_r[2 * (k / 2) + int'(pick_r[k / 2])]
                              : duty_act_r[k];

    pwm_channel u_ch (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .t(tmr),
      .i_duty(duty_use),
      .o_on(gen_on[k])
    );

    // Bottom of a complementary pair is the inverse, low when off
    assign pin_nxt[k] = (override_r ? man_out_r[k]
        : ((compl_r && k % 2 == 1) ? (enable_r && !gen_on[k]) : gen_on[k]))
        && !(dis_x_act_r && map_x_r[k]) && !(dis_y_act_r && map_y_r[k])
        && !fault_s[k];
  end

  // Top/bottom correction source per pair
  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
    // Sense latch: dead time when both off, else half or end point
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        sense_pick_r[p] <= 1'b0;
      end else if (corr_sel_r == CORR_DEAD) begin
        if (!o_pwm[2 * p] && !o_pwm[2 * p + 1]) begin
          sense_pick_r[p] <= sense_s[p];
        end
      end else if (corr_sel_r[1] && (center_r ? tmr.half_pt : tmr.cyc_end)) begin
        sense_pick_r[p] <= sense_s[p];
      end
    end

    // Choice taken at each cycle start
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        pick_r[p] <= 1'b0;
      end else if (cyc_start) begin
        pick_r[p] <= corr_sel_r[1] ? sense_pick_r[p] : pol_act_r[p];
      end
    end
  end

  // Software bank disables act at once, release at a cycle start or while override is selected
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dis_x_act_r <= 1'b0;
      dis_y_act_r <= 1'b0;
    end else begin
      if (dis_x_r) begin
        dis_x_act_r <= 1'b1;
      end else if (cyc_start || override_r) begin
        dis_x_act_r <= 1'b0;
      end
      if (dis_y_r) begin
        dis_y_act_r <= 1'b1;
      end else if (cyc_start || override_r) begin
        dis_y_act_r <= 1'b0;
      end
    end
  end

  // Pin drive; float while disabled unless override is selected
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pwm <= '0;
      o_pwm_oe_n <= '1;
    end else begin
      o_pwm <= pin_nxt;
      o_pwm_oe_n <= {NUM_CH{!(enable_r || override_r)}};
    end
  end

  // Interrupt: reload flag gated by its enable, wake on any source
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_irq <= flag_r && irq_en_r;
      o_wake <= (flag_r && irq_en_r) || fault_irq_s;
    end
  end

  // Counter low byte latch
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_lo_latch_r <= BYTE_RST;
      cnt_latched_r <= 1'b0;
    end else if (i_rd && i_addr == COUNT_HIGH_ADDR) begin
      cnt_lo_latch_r <= tmr.count[7:0];
      cnt_latched_r <= 1'b1;
    end else if (i_rd && i_addr == COUNT_LOW_ADDR) begin
      cnt_latched_r <= 1'b0;
    end
  end

  // Read mux
  assign ctl1_val = {dis_x_r, dis_y_r, irq_en_r, flag_r, corr_sel_r, load_ok_r, enable_r};
  always_comb begin
    rdata_nxt = BYTE_RST;
    if (i_addr >= DUTY_BASE_ADDR && i_addr < MANUAL_ADDR) begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (i_addr == 8'(DUTY_BASE_ADDR + 2 * n)) begin
          rdata_nxt = duty_buf_r[n][15:8];
        end else if (i_addr == 8'(DUTY_BASE_ADDR + 2 * n + 1)) begin
          rdata_nxt = duty_buf_r[n][7:0];
        end
      end
    end else begin
      unique case (i_addr)
        CTRL_ONE_ADDR: rdata_nxt = ctl1_val;
        CTRL_TWO_ADDR: rdata_nxt = {rate_buf_r, pol_buf_r, center_r, psc_buf_r};
        COUNT_HIGH_ADDR: rdata_nxt = {4'h0, tmr.count[COUNT_W-1:8]};
        COUNT_LOW_ADDR: rdata_nxt = cnt_latched_r ? cnt_lo_latch_r : tmr.count[7:0];
        PERIOD_HIGH_ADDR: rdata_nxt = {4'h0, mod_buf_r[COUNT_W-1:8]};
        PERIOD_LOW_ADDR: rdata_nxt = mod_buf_r[7:0];
        MANUAL_ADDR: rdata_nxt = {compl_r, override_r, man_out_r};
        MAP_X_ADDR: rdata_nxt = {2'h0, map_x_r};
        MAP_Y_ADDR: rdata_nxt = {2'h0, map_y_r};
        default: rdata_nxt = BYTE_RST;
      endcase
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= BYTE_RST;
    end else begin
      o_rdata <= i_rd ? rdata_nxt : BYTE_RST;
    end
  end
endmodule

// ==== tb/pwm_stage_model.sv ====
`timescale 1ns/100ps
// Power stage: sense lines report load current direction
module pwm_stage_model (
  // From the block
  input wire logic i_clk,
  input wire logic [5:0] i_pwm_oe_n,
  input wire logic [2:0] i_dir,
  // To the block
  output logic [2:0] o_sense_n
);
  // Pulled up while the stage floats, else low for positive current
  always_ff @(posedge i_clk) o_sense_n <= &i_pwm_oe_n ? 3'h7 : ~i_dir;
endmodule

// ==== tb/pwm_ctl_monitor.sv ====
`timescale 1ns/100ps
module pwm_ctl_monitor (
  // Clock, reset, register port
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Pins and requests
  input wire logic [5:0] o_pwm,
  input wire logic [5:0] o_pwm_oe_n,
  input wire logic i_fault_irq,
  input wire logic o_irq,
  input wire logic o_wake
);
  import pwm_ctl_pkg::*;
  logic en_r; // Enable as written
  logic ovr_r; // Override as written
  logic ien_r; // Irq enable as written
  logic [1:0] off_r; // Cycles fully off, saturating
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Shadow control bits from bus writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_r <= 1'b0;
      ien_r <= 1'b0;
      ovr_r <= 1'b0;
    end else if (i_wr && i_addr == CTRL_ONE_ADDR) begin
      en_r <= i_wdata[C1_ENABLE];
      ien_r <= i_wdata[C1_IRQ_EN];
    end else if (i_wr && i_addr == MANUAL_ADDR) begin
      ovr_r <= i_wdata[MN_OVERRIDE];
    end
  end
  // Off time counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) off_r <= 2'h0;
    else if (en_r || ovr_r) off_r <= 2'h0;
    else if (off_r != 2'h3) off_r <= off_r + 2'h1;
  end
  sequence s_wr(a); i_wr && i_addr == a; endsequence
  sequence s_rd(a); i_rd && i_addr == a; endsequence
  sequence s_flt; i_fault_irq [*4]; endsequence
  property p_float; off_r == 2'h3 |-> &o_pwm_oe_n; endproperty
  a_float: assert property (p_float) else $error("pins driven");
  property p_low; off_r == 2'h3 |-> o_pwm == 6'h00; endproperty
  a_low: assert property (p_low) else $error("pins high");
  property p_cnt0;
    off_r == 2'h3 && $past(i_rd) && $past(i_addr) == COUNT_HIGH_ADDR |-> o_rdata == 8'h00;
  endproperty
  a_cnt0: assert property (p_cnt0) else $error("count not zero");
  property p_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_irq; !$past(ien_r) |-> !o_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq not masked");
  property p_wake; o_irq |-> o_wake; endproperty
  a_wake: assert property (p_wake) else $error("no wake on irq");
  property p_flt; s_flt |-> o_wake; endproperty
  a_flt: assert property (p_flt) else $error("no wake on fault");
  property p_mod;
    s_wr(PERIOD_LOW_ADDR) ##1 !i_wr ##1 s_rd(PERIOD_LOW_ADDR) |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_mod: assert property (p_mod) else $error("modulus readback");
endmodule
bind pwm_ctl_top pwm_ctl_monitor pwm_ctl_monitor_i (.i_clk, .i_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_pwm, .o_pwm_oe_n, .i_fault_irq, .o_irq, .o_wake);

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
  import pwm_ctl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0, i_rd = 1'b0, i_fault_irq = 1'b0;
  logic [2:0] dir = 3'h0; // Load current direction
  logic [5:0] fault_off = 6'h00; // Fault block disable levels
  logic [7:0] o_rdata;
  logic [5:0] o_pwm, o_pwm_oe_n;
  logic [2:0] sense_n;
  logic o_irq, o_wake;
  logic rd_d = 1'b0; // Read answer due
  logic [7:0] exp_q[$]; // Expected read data
  logic [31:0] rnd = 32'h3a4b_36b7;
  int n_errors = 0;
  int total_checks = 0;
  // Duty per channel and on-clocks per 64-clock period
  logic [15:0] duty [6] = '{16'h0000, 16'hffff, 16'h0008, 16'h0004, 16'h7fff, 16'h0002};
  logic [7:0] on_t [6] = '{8'h00, 8'h00, 8'h40, 8'h20, 8'h40, 8'h10};
  pwm_ctl_top pwm_ctl_top_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pwm,
    .o_pwm_oe_n, .i_sense_n(sense_n), .i_fault_off(fault_off), .i_fault_irq, .o_irq, .o_wake);
  pwm_stage_model pwm_stage_model_i (.i_clk, .i_pwm_oe_n(o_pwm_oe_n), .i_dir(dir),
    .o_sense_n(sense_n));
  initial forever #2.5 i_clk = ~i_clk;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // One-cycle bus write
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // One-cycle bus read, answer noted for the watcher
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  // Bounded wait for the reload interrupt
  task automatic wait_irq();
    int n = 0;
    while (o_irq !== 1'b1 && n < 1000) begin
      @(posedge i_clk);
      n++;
    end
    chk("irq", 8'h01, {7'h00, o_irq});
  endtask
  // Count on-clocks of each pin over one period
  task automatic meas();
    logic [7:0] c [6] = '{default: 8'h00};
    repeat (64) begin
      @(posedge i_clk);
      for (int k = 0; k < 6; k++) c[k] += {7'h00, o_pwm[k]};
    end
    for (int k = 0; k < 6; k++) chk("on time", on_t[k], c[k]);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compare each read answer with the oldest note
  always @(posedge i_clk) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), o_rdata);
    rd_d <= i_rd;
  end
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 12; k++) rd(DUTY_BASE_ADDR + 8'(k), 8'h00);
    rd(8'h40, 8'h00);
    chk("oe_n", 8'h3f, {2'b00, o_pwm_oe_n});
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      dir <= rnd[10:8];
      wr(DUTY_BASE_ADDR + 8'(k), rnd[7:0]);
      rd(DUTY_BASE_ADDR + 8'(k), rnd[7:0]);
    end
    $display("test readback done");
    // Edge mode, modulus 8, prescale 8, reload every 8 periods
    wr(PERIOD_HIGH_ADDR, 8'h00);
    wr(PERIOD_LOW_ADDR, 8'h08);
    rd(PERIOD_LOW_ADDR, 8'h08);
    for (int k = 0; k < 6; k++) begin
      wr(DUTY_BASE_ADDR + 8'(2 * k), duty[k][15:8]);
      wr(DUTY_BASE_ADDR + 8'(2 * k + 1), duty[k][7:0]);
    end
    wr(CTRL_TWO_ADDR, 8'hc3);
    wr(MAP_X_ADDR, 8'h3f);
    rd(CTRL_ONE_ADDR, 8'h00);
    wr(CTRL_ONE_ADDR, 8'h03);
    repeat (10) @(posedge i_clk);
    chk("oe_n", 8'h00, {2'b00, o_pwm_oe_n});
    meas();
    rd(CTRL_ONE_ADDR, 8'h11);
    // Bank X soft disable, then release
    wr(CTRL_ONE_ADDR, 8'h81);
    repeat (3) @(posedge i_clk);
    chk("pwm", 8'h00, {2'b00, o_pwm});
    rd(CTRL_ONE_ADDR, 8'h81);
    wr(CTRL_ONE_ADDR, 8'h21);
    repeat (70) @(posedge i_clk);
    meas();
    $display("test generator done");
    wait_irq();
    rd(CTRL_ONE_ADDR, 8'h31);
    wr(CTRL_ONE_ADDR, 8'h21);
    rd(CTRL_ONE_ADDR, 8'h21);
    chk("irq", 8'h00, {7'h00, o_irq});
    // A reload between arming and the write keeps the flag
    wait_irq();
    rd(CTRL_ONE_ADDR, 8'h31);
    repeat (600) @(posedge i_clk);
    wr(CTRL_ONE_ADDR, 8'h21);
    rd(CTRL_ONE_ADDR, 8'h31);
    $display("test flag done");
    // Complementary pairs, sense picks odd values at cycle end
    dir <= 3'h7;
    wr(MANUAL_ADDR, 8'h80);
    wr(CTRL_ONE_ADDR, 8'h3d);
    repeat (140) @(posedge i_clk);
    on_t = '{8'h00, 8'h40, 8'h20, 8'h20, 8'h10, 8'h30};
    meas();
    $display("test correction done");
    wr(CTRL_ONE_ADDR, 8'h20);
    repeat (4) @(posedge i_clk);
    rd(CTRL_ONE_ADDR, 8'h30);
    rd(COUNT_HIGH_ADDR, 8'h00);
    rd(COUNT_LOW_ADDR, 8'h00);
    chk("irq", 8'h01, {7'h00, o_irq});
    chk("oe_n", 8'h3f, {2'b00, o_pwm_oe_n});
    chk("pwm", 8'h00, {2'b00, o_pwm});
    fault_off <= 6'h02;
    wr(MANUAL_ADDR, 8'h6a);
    repeat (3) @(posedge i_clk);
    chk("pwm", 8'h28, {2'b00, o_pwm});
    chk("oe_n", 8'h00, {2'b00, o_pwm_oe_n});
    wr(MANUAL_ADDR, 8'h00);
    wr(CTRL_ONE_ADDR, 8'h00);
    i_fault_irq <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk("irq", 8'h00, {7'h00, o_irq});
    chk("wake", 8'h01, {7'h00, o_wake});
    $display("test disable done");
    repeat (3) @(posedge i_clk);
    results();
  end
endmodule
